// File: hw/smcs_pkg.sv
// Purpose: Shared constants and types for the signal modulator carrier select block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses
package smcs_pkg;
   localparam logic [3:0] OFF_HIGH_CAR = 4'h0;
   localparam logic [3:0] OFF_LOW_CAR = 4'h4;
   localparam logic [3:0] OFF_MOD_CTL = 4'h8;
   localparam logic [3:0] OFF_MOD_SRC = 4'hc;
   // Carrier control fields
   localparam int CAR_PIN_DIS_BIT = 7;
   localparam int CAR_INV_BIT = 6;
   localparam int CAR_SYNC_BIT = 5;
   localparam logic [7:0] CAR_WMASK = 8'hef;
   // Modulation control fields
   localparam int MC_EN_BIT = 7;
   localparam int MC_OE_BIT = 6;
   localparam int MC_SLEW_BIT = 5;
   localparam int MC_OINV_BIT = 4;
   localparam int MC_OUT_BIT = 3;
   localparam int MC_MBIT_BIT = 0;
   localparam logic [7:0] MC_WMASK = 8'hf1;
   localparam logic [7:0] MC_RESET = 8'h20;
   localparam logic [7:0] SRC_WMASK = 8'h8f;
   localparam int SRC_PIN_DIS_BIT = 7;
   // Carrier select codes
   localparam logic [3:0] SEL_GND = 4'h0;
   localparam logic [3:0] SEL_PIN1 = 4'h1;
   localparam logic [3:0] SEL_PIN2 = 4'h2;
   localparam logic [3:0] SEL_REFCLK = 4'h3;
   localparam logic [3:0] SEL_PWM = 4'h4;
   // Modulation source codes
   localparam logic [3:0] MS_MBIT = 4'h0;
   localparam logic [3:0] MS_PIN = 4'h1;
   localparam logic [3:0] MS_PWM = 4'h2;
   localparam logic [3:0] MS_CMP = 4'h6;
   localparam logic [3:0] MS_SDO = 4'h8;
   localparam logic [3:0] MS_TX = 4'ha;
   // Carrier sources sampled in system clock domain
   typedef struct packed {
      logic pin_one;
      logic pin_two;
      logic ref_clk;
      logic pwm;
   } smcs_car_src_t;
   // Modulation sources
   typedef struct packed {
      logic pin;
      logic pwm;
      logic cmp;
      logic sdo;
      logic tx;
   } smcs_mod_src_t;
   // Per-peripheral pin disable requests
   typedef struct packed {
      logic pwm;
      logic ref_clk;
      logic cmp;
      logic sdo;
      logic tx;
   } smcs_pin_dis_t;
endpackage

// File: hw/smcs_top.sv
// Purpose: Carrier selection, synchronisation and mixing of a data signal modulator
// Assumes: Single 10 MHz clock mclk; all carrier and modulation sources asynchronous
// Notes: Carrier and source registers keep state across resets; mod control reloads 0x20 on reset
`timescale 1ns/1ps
module smcs_top
   import smcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire smcs_car_src_t car_src,
   input wire smcs_mod_src_t mod_src,
   output logic mod_out,
   output logic mod_out_oe,
   output logic mod_out_slew,
   output smcs_pin_dis_t pin_dis
);
   // Three-stage synchronisers for every asynchronous input
   logic [8:0] raw_in;
   logic [8:0] sync1_ff, sync2_ff, sync3_ff, clean_ff;
   logic [8:0] nxt_clean;
   assign raw_in = {car_src, mod_src};

   // Register state
   logic [7:0] hcar_ff, lcar_ff, mctl_ff, msrc_ff;
   logic [7:0] nxt_hcar, nxt_lcar, nxt_mctl, nxt_msrc;
   logic [31:0] nxt_prdata;
   logic nxt_pready, nxt_pslverr;
   // Mixer state
   logic use_high_ff, nxt_use_high;
   logic hc_prev_ff, lc_prev_ff;
   logic nxt_mod_out, nxt_oe, nxt_slew;
   smcs_pin_dis_t nxt_pin_dis;
   logic hc, lc, modsig;
   smcs_car_src_t cs;
   smcs_mod_src_t ms;

   // Map a select code to a carrier; unlisted codes give constant low
   function automatic logic pick_car(input logic [3:0] sel, input smcs_car_src_t s, input logic pin2_ok);
      logic r;
      r = 1'b0;
      case (sel)
         SEL_PIN1: r = s.pin_one;
         SEL_PIN2: r = pin2_ok & s.pin_two;
         SEL_REFCLK: r = s.ref_clk;
         SEL_PWM: r = s.pwm;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Pin-change filter: update only when the later stages agree
   always_comb begin
      for (int i = 0; i < 9; i++) begin
         nxt_clean[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : clean_ff[i];
      end
   end

   always_ff @(posedge mclk) begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (!rst_n) begin
         clean_ff <= 9'h000;
      end else begin
         clean_ff <= nxt_clean;
      end
   end

   assign cs = clean_ff[8:5];
   assign ms = clean_ff[4:0];

   // Carrier selection with polarity; edge seen after inversion
   assign hc = pick_car(hcar_ff[3:0], cs, 1'b1) ^ hcar_ff[CAR_INV_BIT];
   assign lc = pick_car(lcar_ff[3:0], cs, 1'b0) ^ lcar_ff[CAR_INV_BIT];

   // Modulation signal from source select
   always_comb begin
      modsig = 1'b0;
      case (msrc_ff[3:0])
         MS_MBIT: modsig = mctl_ff[MC_MBIT_BIT];
         MS_PIN: modsig = ms.pin;
         MS_PWM: modsig = ms.pwm;
         MS_CMP: modsig = ms.cmp;
         MS_SDO: modsig = ms.sdo;
         MS_TX: modsig = ms.tx;
         default: modsig = 1'b0;
      endcase
   end

   // Carrier switch; sync holds the old carrier until its falling edge
   always_comb begin
      nxt_use_high = use_high_ff;
      if (modsig && !use_high_ff) begin
         if (!lcar_ff[CAR_SYNC_BIT] || (lc_prev_ff && !lc)) begin
            nxt_use_high = 1'b1;
         end
      end else if (!modsig && use_high_ff) begin
         if (!hcar_ff[CAR_SYNC_BIT] || (hc_prev_ff && !hc)) begin
            nxt_use_high = 1'b0;
         end
      end
      if (!mctl_ff[MC_EN_BIT]) begin
         nxt_use_high = modsig;
      end
   end

   // Output mixing, polarity and pin controls
   always_comb begin
      nxt_mod_out = 1'b0;
      if (mctl_ff[MC_EN_BIT]) begin
         nxt_mod_out = (nxt_use_high ? hc : lc) ^ mctl_ff[MC_OINV_BIT];
      end
      nxt_oe = mctl_ff[MC_OE_BIT];
      nxt_slew = mctl_ff[MC_SLEW_BIT];
      // Disable requests go to whichever peripheral is selected
      nxt_pin_dis = '0;
      if (hcar_ff[CAR_PIN_DIS_BIT] && hcar_ff[3:0] == SEL_PWM) nxt_pin_dis.pwm = 1'b1;
      if (hcar_ff[CAR_PIN_DIS_BIT] && hcar_ff[3:0] == SEL_REFCLK) nxt_pin_dis.ref_clk = 1'b1;
      if (lcar_ff[CAR_PIN_DIS_BIT] && lcar_ff[3:0] == SEL_PWM) nxt_pin_dis.pwm = 1'b1;
      if (lcar_ff[CAR_PIN_DIS_BIT] && lcar_ff[3:0] == SEL_REFCLK) nxt_pin_dis.ref_clk = 1'b1;
      if (msrc_ff[SRC_PIN_DIS_BIT]) begin
         case (msrc_ff[3:0])
            MS_PWM: nxt_pin_dis.pwm = 1'b1;
            MS_CMP: nxt_pin_dis.cmp = 1'b1;
            MS_SDO: nxt_pin_dis.sdo = 1'b1;
            MS_TX: nxt_pin_dis.tx = 1'b1;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      hc_prev_ff <= hc;
      lc_prev_ff <= lc;
      if (!rst_n) begin
         use_high_ff <= 1'b0;
         mod_out <= 1'b0;
         mod_out_oe <= 1'b0;
         mod_out_slew <= 1'b1;
         pin_dis <= '0;
      end else begin
         use_high_ff <= nxt_use_high;
         mod_out <= nxt_mod_out;
         mod_out_oe <= nxt_oe;
         mod_out_slew <= nxt_slew;
         pin_dis <= nxt_pin_dis;
      end
   end

   // APB slave: one wait-free access, unmapped reads zero with error
   always_comb begin
      nxt_hcar = hcar_ff & CAR_WMASK;
      nxt_lcar = lcar_ff & CAR_WMASK;
      nxt_msrc = msrc_ff;
      nxt_mctl = mctl_ff;
      nxt_mctl[MC_OUT_BIT] = mod_out;
      nxt_prdata = 32'h0000_0000;
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      if (psel && !penable) begin
         nxt_pready = 1'b1;
         nxt_pslverr = (paddr[31:4] != 28'h0) || (paddr[1:0] != 2'h0);
         if (!nxt_pslverr) begin
            case (paddr[3:0])
               OFF_HIGH_CAR: nxt_prdata = {24'h0, hcar_ff};
               OFF_LOW_CAR: nxt_prdata = {24'h0, lcar_ff};
               OFF_MOD_CTL: nxt_prdata = {24'h0, mctl_ff};
               OFF_MOD_SRC: nxt_prdata = {24'h0, msrc_ff};
               default: nxt_pslverr = 1'b1;
            endcase
         end
      end
      if (psel && penable && pready && pwrite && !pslverr) begin
         case (paddr[3:0])
            OFF_HIGH_CAR: nxt_hcar = pwdata[7:0] & CAR_WMASK;
            OFF_LOW_CAR: nxt_lcar = pwdata[7:0] & CAR_WMASK;
            OFF_MOD_CTL: nxt_mctl = (pwdata[7:0] & MC_WMASK) | (nxt_mctl & ~MC_WMASK); // Live state bit kept
            OFF_MOD_SRC: nxt_msrc = pwdata[7:0] & SRC_WMASK;
            default: ;
         endcase
      end
      if (!rst_n) begin
         nxt_mctl = MC_RESET;
      end
   end

   // Carrier and source regs keep value over reset
   always_ff @(posedge mclk) begin
      hcar_ff <= nxt_hcar;
      lcar_ff <= nxt_lcar;
      msrc_ff <= nxt_msrc;
      mctl_ff <= nxt_mctl;
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= nxt_prdata;
         pready <= nxt_pready;
         pslverr <= nxt_pslverr;
      end
   end

   // Enable, reset and output mixing
   AST_DISABLED_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
      !mctl_ff[MC_EN_BIT] |=> !mod_out)
      else $error("output active while disabled");
   AST_RESET_DIS: assert property (@(posedge mclk)
      !rst_n |=> !mctl_ff[MC_EN_BIT])
      else $error("reset left module enabled");
   AST_MIX: assert property (@(posedge mclk) disable iff (!rst_n)
      mctl_ff[MC_EN_BIT]
      |=> mod_out == (($past(nxt_use_high) ? $past(hc) : $past(lc)) ^ $past(mctl_ff[MC_OINV_BIT])))
      else $error("mixed output wrong");
   // A low high-side carrier, when chosen, must show up as the polarity bit
   AST_OUT_INVERT: assert property (@(posedge mclk) disable iff (!rst_n)
      mctl_ff[MC_EN_BIT] && nxt_use_high && !hc |=> mod_out == $past(mctl_ff[MC_OINV_BIT]))
      else $error("output polarity wrong");
   // Unimplemented bit never holds a one
   AST_BIT4_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
      !hcar_ff[4] && !lcar_ff[4])
      else $error("bit four set");
   // Switching; a sync hold must block the switch until the carrier falls
   AST_HSYNC_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      mctl_ff[MC_EN_BIT] && use_high_ff && !modsig && hcar_ff[CAR_SYNC_BIT] && !(hc_prev_ff && !hc)
      |=> use_high_ff)
      else $error("high carrier left early");
   AST_LSYNC_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      mctl_ff[MC_EN_BIT] && !use_high_ff && modsig && lcar_ff[CAR_SYNC_BIT] && !(lc_prev_ff && !lc)
      |=> !use_high_ff)
      else $error("low carrier left early");
   AST_NOSYNC_SWITCH: assert property (@(posedge mclk) disable iff (!rst_n)
      mctl_ff[MC_EN_BIT] && !hcar_ff[CAR_SYNC_BIT] && !lcar_ff[CAR_SYNC_BIT]
      |=> use_high_ff == $past(modsig))
      else $error("unsynchronised switch late");
   // Select tables, held against the filtered inputs directly
   AST_HIGH_PIN1: assert property (@(posedge mclk) disable iff (!rst_n)
      hcar_ff[3:0] == SEL_PIN1 |-> hc == (cs.pin_one ^ hcar_ff[CAR_INV_BIT]))
      else $error("high pin one not selected");
   AST_HIGH_PIN2: assert property (@(posedge mclk) disable iff (!rst_n)
      hcar_ff[3:0] == SEL_PIN2 |-> hc == (cs.pin_two ^ hcar_ff[CAR_INV_BIT]))
      else $error("high pin two not selected");
   AST_HIGH_REFCLK: assert property (@(posedge mclk) disable iff (!rst_n)
      hcar_ff[3:0] == SEL_REFCLK |-> hc == (cs.ref_clk ^ hcar_ff[CAR_INV_BIT]))
      else $error("high reference clock not selected");
   AST_HIGH_PWM: assert property (@(posedge mclk) disable iff (!rst_n)
      hcar_ff[3:0] == SEL_PWM |-> hc == (cs.pwm ^ hcar_ff[CAR_INV_BIT]))
      else $error("high pwm not selected");
   AST_HIGH_NONE: assert property (@(posedge mclk) disable iff (!rst_n)
      hcar_ff[3:0] == SEL_GND || hcar_ff[3:0] > SEL_PWM |-> hc == hcar_ff[CAR_INV_BIT])
      else $error("high unconnected code not low");
   AST_LOW_PIN1: assert property (@(posedge mclk) disable iff (!rst_n)
      lcar_ff[3:0] == SEL_PIN1 |-> lc == (cs.pin_one ^ lcar_ff[CAR_INV_BIT]))
      else $error("low pin one not selected");
   AST_LOW_REFCLK: assert property (@(posedge mclk) disable iff (!rst_n)
      lcar_ff[3:0] == SEL_REFCLK |-> lc == (cs.ref_clk ^ lcar_ff[CAR_INV_BIT]))
      else $error("low reference clock not selected");
   AST_LOW_PWM: assert property (@(posedge mclk) disable iff (!rst_n)
      lcar_ff[3:0] == SEL_PWM |-> lc == (cs.pwm ^ lcar_ff[CAR_INV_BIT]))
      else $error("low pwm not selected");
   AST_LOW_NO_PIN2: assert property (@(posedge mclk) disable iff (!rst_n)
      lcar_ff[3:0] == SEL_GND || lcar_ff[3:0] == SEL_PIN2 || lcar_ff[3:0] > SEL_PWM
      |-> lc == lcar_ff[CAR_INV_BIT])
      else $error("low unconnected code not low");
   // Pin release requests follow the disable bits
   AST_PIN_DIS: assert property (@(posedge mclk) disable iff (!rst_n)
      hcar_ff[CAR_PIN_DIS_BIT] && hcar_ff[3:0] == SEL_PWM |=> pin_dis.pwm)
      else $error("pwm pin not released");
   AST_LPIN_DIS: assert property (@(posedge mclk) disable iff (!rst_n)
      lcar_ff[CAR_PIN_DIS_BIT] && lcar_ff[3:0] == SEL_REFCLK |=> pin_dis.ref_clk)
      else $error("refclk pin not released");
   AST_PIN_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
      !hcar_ff[CAR_PIN_DIS_BIT] && !lcar_ff[CAR_PIN_DIS_BIT] && !msrc_ff[SRC_PIN_DIS_BIT] |=> pin_dis == '0)
      else $error("pin released without disable bit");
   // Filter may only take a bit whose later stages agreed
   AST_FILTER: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> ((clean_ff ^ $past(clean_ff)) & ($past(sync2_ff) ^ $past(sync3_ff))) == 9'h000)
      else $error("input taken before stages agree");
   // Main scenarios reached
   COV_ENABLED: cover property (@(posedge mclk) disable iff (!rst_n) mctl_ff[MC_EN_BIT] && mod_out);
   COV_NOSYNC: cover property (@(posedge mclk) disable iff (!rst_n) !hcar_ff[CAR_SYNC_BIT] && use_high_ff ##1 !use_high_ff);
   COV_HSYNC: cover property (@(posedge mclk) disable iff (!rst_n) hcar_ff[CAR_SYNC_BIT] && use_high_ff ##1 !use_high_ff);
   COV_LSYNC: cover property (@(posedge mclk) disable iff (!rst_n) lcar_ff[CAR_SYNC_BIT] && !use_high_ff ##1 use_high_ff);
   COV_INVERT: cover property (@(posedge mclk) disable iff (!rst_n) mctl_ff[MC_OINV_BIT] && mctl_ff[MC_EN_BIT]);
endmodule

// File: bench/smcs_src_model.sv
// Purpose: Carrier source model that drives the asynchronous carrier inputs
// Assumes: The bench commands the levels; slow mode lags them
// Notes: Carriers are plain levels, so no idle pattern is needed
`timescale 1ns/1ps
module smcs_src_model
   import smcs_pkg::*;
(
   input wire logic mclk,
   input wire smcs_car_src_t want,
   input wire logic slow,
   output smcs_car_src_t car_src
);
   smcs_car_src_t dly_ff [3];
   // Three-cycle lag stands in for a sluggish source
   always_ff @(posedge mclk) begin
      dly_ff[0] <= want;
      dly_ff[1] <= dly_ff[0];
      dly_ff[2] <= dly_ff[1];
   end
   assign car_src = slow ? dly_ff[2] : want;
endmodule

// File: bench/tb_top.sv
// Purpose: Self-checking bench for carrier select, mixing and registers
// Assumes: APB answers in one access cycle; input latency about five edges
// Notes: Settle time of 12 cycles covers the slow source lag too
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top
   import smcs_pkg::*;
();
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic slow = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, mod_out, mod_out_oe, mod_out_slew, err;
   smcs_car_src_t want = '0;
   smcs_car_src_t car_src;
   smcs_mod_src_t mod_src = '0;
   smcs_pin_dis_t pin_dis;
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 35;
   smcs_top smcs_top_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .car_src(car_src),
      .mod_src(mod_src), .mod_out(mod_out), .mod_out_oe(mod_out_oe), .mod_out_slew(mod_out_slew), .pin_dis(pin_dis));
   smcs_src_model smcs_src_model_inst (.mclk(mclk), .want(want), .slow(slow), .car_src(car_src));
   always #50 mclk = ~mclk;
   // Hang guard; the whole run needs well under this
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // One APB transfer; waits for pready rather than assuming a latency
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic do_reset;
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
   endtask
   // Control write, then let the synchroniser pipeline drain
   task automatic step(input logic [7:0] c);
      apb(1'b1, 32'(OFF_MOD_CTL), {24'h0, c});
      repeat (12) @(posedge mclk);
   endtask
   function automatic logic car_exp(logic [3:0] s, smcs_car_src_t c, logic lo);
      case (s)
         SEL_PIN1: return c.pin_one;
         SEL_PIN2: return lo ? 1'b0 : c.pin_two;
         SEL_REFCLK: return c.ref_clk;
         SEL_PWM: return c.pwm;
         default: return 1'b0;
      endcase
   endfunction
   function automatic logic ms_exp(logic [3:0] s, smcs_mod_src_t m, logic b);
      case (s)
         MS_MBIT: return b;
         MS_PIN: return m.pin;
         MS_PWM: return m.pwm;
         MS_CMP: return m.cmp;
         MS_SDO: return m.sdo;
         MS_TX: return m.tx;
         default: return 1'b0;
      endcase
   endfunction
   initial begin
      logic [7:0] v;
      do_reset();
      apb(1'b0, 32'(OFF_MOD_CTL), 32'h0);
      `CHK("mod_ctl", 32'h20, rd)
      `CHK("slew", 1'b1, mod_out_slew)
      // Random register contents; bit four must drop out
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         apb(1'b1, 32'(i[0] ? OFF_LOW_CAR : OFF_HIGH_CAR), {24'h0, v});
         apb(1'b0, 32'(i[0] ? OFF_LOW_CAR : OFF_HIGH_CAR), 32'h0);
         `CHK("car_reg", {24'h0, v & CAR_WMASK}, rd)
      end
      apb(1'b0, 32'h10, 32'h0);
      `CHK("slverr", 1'b1, err)
      // Reset in mid-run keeps carrier setup but disables the module
      apb(1'b1, 32'(OFF_MOD_CTL), 32'h80);
      do_reset();
      apb(1'b0, 32'(OFF_LOW_CAR), 32'h0);
      `CHK("car_keep", {24'h0, v & CAR_WMASK}, rd)
      apb(1'b0, 32'(OFF_MOD_CTL), 32'h0);
      `CHK("mod_ctl_rst", 32'h20, rd)
      apb(1'b1, 32'(OFF_HIGH_CAR), 32'h0);
      apb(1'b1, 32'(OFF_LOW_CAR), 32'h0);
      apb(1'b1, 32'(OFF_MOD_SRC), 32'h0);
      // Every select code of both carriers, random invert bits and levels
      for (int s = 0; s < 32; s++) begin
         v = 8'($random(seed));
         want <= smcs_car_src_t'(v[3:0]);
         slow <= v[4];
         apb(1'b1, 32'(s[4] ? OFF_LOW_CAR : OFF_HIGH_CAR), {24'h0, 1'b0, v[5], 2'b0, 4'(s)});
         step({1'b1, v[7], 1'b1, v[6], 3'b0, ~s[4]});
         `CHK("mod_out", car_exp(4'(s), smcs_car_src_t'(v[3:0]), s[4]) ^ v[5] ^ v[6], mod_out)
         `CHK("oe", v[7], mod_out_oe)
      end
      slow <= 1'b0;
      apb(1'b1, 32'(OFF_HIGH_CAR), 32'h40);
      apb(1'b1, 32'(OFF_LOW_CAR), 32'h0);
      // Every modulation source code with random source levels
      for (int i = 0; i < 16; i++) begin
         v = 8'($random(seed));
         mod_src <= smcs_mod_src_t'(v[4:0]);
         apb(1'b1, 32'(OFF_MOD_SRC), 32'(i));
         step(8'ha0 | 8'(v[5]));
         `CHK("mod_sel", ms_exp(4'(i), smcs_mod_src_t'(v[4:0]), v[5]), mod_out)
      end
      apb(1'b1, 32'(OFF_MOD_SRC), 32'h0);
      step(8'h21);
      `CHK("disabled", 1'b0, mod_out)
      apb(1'b1, 32'(OFF_HIGH_CAR), 32'h84);
      apb(1'b1, 32'(OFF_LOW_CAR), 32'h83);
      step(8'ha1);
      `CHK("pin_dis_h", 1'b1, pin_dis.pwm)
      `CHK("pin_dis_l", 1'b1, pin_dis.ref_clk)
      apb(1'b1, 32'(OFF_HIGH_CAR), 32'h04);
      step(8'ha1);
      `CHK("pin_en_h", 1'b0, pin_dis.pwm)
      // High sync: a steady high carrier holds off the switch
      // Low side is inverted pin one, so the output shows which carrier won
      want <= smcs_car_src_t'(4'h8);
      apb(1'b1, 32'(OFF_LOW_CAR), 32'h41);
      apb(1'b1, 32'(OFF_HIGH_CAR), 32'h21);
      step(8'ha1);
      step(8'ha0);
      `CHK("h_sync_hold", 1'b1, mod_out)
      want <= '0;
      repeat (12) @(posedge mclk);
      `CHK("h_sync_fall", 1'b1, mod_out)
      want <= smcs_car_src_t'(4'h8);
      apb(1'b1, 32'(OFF_HIGH_CAR), 32'h01);
      step(8'ha1);
      step(8'ha0);
      `CHK("h_nosync", 1'b0, mod_out)
      // Low sync on an inverted carrier: the edge is judged after inversion
      want <= '0;
      apb(1'b1, 32'(OFF_HIGH_CAR), 32'h02);
      apb(1'b1, 32'(OFF_LOW_CAR), 32'h61);
      step(8'ha0);
      step(8'ha1);
      `CHK("l_sync_hold", 1'b1, mod_out)
      want <= smcs_car_src_t'(4'hc);
      repeat (12) @(posedge mclk);
      `CHK("l_sync_fall", 1'b1, mod_out)
      report_and_stop();
   end
endmodule
